//--- rtl/adc_cmd_pkg.sv
// constants, field positions and types for the adc command byte decoder
package adc_cmd_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // command byte select bits
    localparam int CONV_SEL_BIT  = 7;
    localparam int SETUP_SEL_BIT = 6;
    localparam int AVG_SEL_BIT   = 5;
    localparam int RST_SEL_BIT   = 4;
    // conversion byte fields
    localparam int CH_HI         = 6;
    localparam int CH_LO         = 3;
    localparam int SCAN_HI       = 2;
    localparam int SCAN_LO       = 1;
    localparam int TEMP_BIT      = 0;
    // setup byte fields
    localparam int CLK_HI        = 5;
    localparam int CLK_LO        = 4;
    localparam int REF_HI        = 3;
    localparam int REF_LO        = 2;
    localparam int PTR_HI        = 1;
    localparam int PTR_LO        = 0;
    // averaging and reset byte fields
    localparam int MEAN_EN_BIT   = 4;
    localparam int MEAN_HI       = 3;
    localparam int MEAN_LO       = 2;
    localparam int REP_HI        = 1;
    localparam int REP_LO        = 0;
    localparam int RST_FIFO_BIT  = 3;
    // reset values
    localparam logic [7:0] CONV_RST  = 8'h00;
    localparam logic [7:0] SETUP_RST = 8'h20;
    localparam logic [7:0] AVG_RST   = 8'h00;
    localparam logic [7:0] RSTR_RST  = 8'h00;
    localparam logic [7:0] UPAIR_RST = 8'h00;
    localparam logic [7:0] SPAIR_RST = 8'h00;
    // timing: least times, rounded up to whole clock cycles
    localparam int T_CNV_NS  = 3500;
    localparam int T_TS_NS   = 20000;
    localparam int T_RP_NS   = 65000;
    localparam int TCNV_CYC  = (T_CNV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TTS_CYC   = (T_TS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRP_CYC   = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // clock modes, reference modes, scan patterns, sequencer states
    localparam logic [1:0] CLK_SERIAL   = 2'h3;
    localparam logic [1:0] CLK_TRIG_HLD = 2'h1;
    localparam logic [1:0] REF_INT_AUTO = 2'h0;
    localparam logic [1:0] REF_EXT_DIFF = 2'h3;
    typedef enum logic [1:0] {
        SCAN_LOW_UP = 2'b00,
        SCAN_UP_TOP = 2'b01,
        SCAN_REPEAT = 2'b10,
        SCAN_ONCE   = 2'b11
    } scan_pattern_t;
    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_WAKE   = 3'b001,
        S_TEMP   = 3'b010,
        S_SEEK   = 3'b011,
        S_SAMPLE = 3'b100,
        S_WAIT   = 3'b101,
        S_DONE   = 3'b110
    } scan_state_t;
endpackage

//--- rtl/adc_command_byte_decoder.sv
// serial command byte decoder, register set and scan request sequencer
`timescale 1ns/100ps
// Behaviour
// - bit7 selects conversion, 01 setup, 001 averaging, 0001 reset
// - conversion byte: channel bits 6..3, scan pattern bits 2..1, temperature bit 0
// - channel field is a plain binary channel number 0..15
// - temperature request gives one temperature result, first in the scan
// - pattern 00 converts channels 0 up to N
// - pattern 01 converts channels N up to the top channel
// - pattern 10 repeats channel N, repeat count sets result count
// - pattern 11 converts channel N once
// - one result per single channel or pair, plus optional temperature
// - scan starts on conversion write (modes 1x) or trigger low pulse (0x)
// - channels reassigned as trigger or low reference are skipped
// - differential top pair with a reassigned member is ignored entirely; single-ended, only that member is skipped
// - timed modes: slot per result is sample time times mean count
// - wake-up only for auto-off internal reference; temperature time only if asked
// - mode 01 follows trigger hold time; mode 11 follows serial timing
// - pair register bit 7 is pair 0/1 down to bit 0 for pair 14/15
// - averaging: enable bit4, mean bits 3..2, repeat bits 1..0; reset uses bit3
// - all six registers written only through the serial port
// - transfer starts on chip select fall, msb first, rising serial clock
// - pointer 10/11 sends the next byte to unsigned/signed pair register
// - mode 11 disables scanning and averaging
// - averaging only while the mean enable bit is set
module adc_command_byte_decoder
    import adc_cmd_pkg::*;
#(
    parameter int NUM_CHANNELS = 16
) (
    input  wire logic       REF_CLK,
    input  wire logic       RESETN,
    input  wire logic       SCLK,
    input  wire logic       CS_N,
    input  wire logic       DIN,
    input  wire logic       SAMPLE_TRIG_N,
    output logic            REQ_VALID,
    output logic [3:0]      REQ_CHANNEL,
    output logic            REQ_TEMP,
    output logic            REQ_DIFF,
    output logic            REQ_SIGNED,
    output logic [5:0]      REQ_MEAN_COUNT,
    output logic            SCAN_BUSY,
    output logic            SCAN_DONE,
    output logic            FIFO_CLEAR,
    output logic [1:0]      CLOCK_MODE,
    output logic [1:0]      REF_MODE
);

    if (NUM_CHANNELS != 8 && NUM_CHANNELS != 12 && NUM_CHANNELS != 16) begin : g_bad_count
        $error("NUM_CHANNELS must be 8, 12 or 16");
    end

    localparam logic [4:0] TOP_CH = 5'(NUM_CHANNELS - 1);
    localparam logic [4:0] REF_CH = 5'(NUM_CHANNELS - 2);

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: shift in on rising serial clock
    logic [2:0] bit_cnt;
    logic [6:0] shift;
    logic [7:0] byte_hold;
    logic       tog;

    // chip select high clears the bit count without needing a clock edge
    always_ff @(posedge SCLK or posedge CS_N) begin
        if (CS_N) begin
            bit_cnt <= 3'h0;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    always_ff @(posedge SCLK) begin
        shift <= {shift[5:0], DIN};
    end

    // byte_hold stays still for eight more edges, long after the toggle is seen
    always_ff @(posedge SCLK or negedge RESETN) begin
        if (!RESETN) begin
            byte_hold <= 8'h00;
            tog       <= 1'b0;
        end else if (bit_cnt == 3'h7) begin
            byte_hold <= {shift, DIN};
            tog       <= ~tog;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // crossings into the reference clock domain
    logic tog_s1, tog_s2, tog_s3;
    logic cs_s1, cs_s2, cs_s3;
    logic tr_s1, tr_s2, tr_s3;

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            {tog_s1, tog_s2, tog_s3} <= 3'h0;
            {cs_s1, cs_s2, cs_s3}    <= 3'h7;
            {tr_s1, tr_s2, tr_s3}    <= 3'h7;
        end else begin
            {tog_s1, tog_s2, tog_s3} <= {tog, tog_s1, tog_s2};
            {cs_s1, cs_s2, cs_s3}    <= {CS_N, cs_s1, cs_s2};
            {tr_s1, tr_s2, tr_s3}    <= {SAMPLE_TRIG_N, tr_s1, tr_s2};
        end
    end

    logic byte_stb, cs_rise, trig_fall;
    assign byte_stb  = tog_s2 ^ tog_s3;
    assign cs_rise   = cs_s2 & ~cs_s3;
    assign trig_fall = ~tr_s2 & tr_s3;

    ////////////////////////////////////////////////////////////////////////////////
    // register file
    logic [7:0] conv_reg, setup_reg, avg_reg, rst_reg, upair, spair;
    logic       pend_pair, pend_signed, conv_wr, fifo_clr;

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            conv_reg    <= CONV_RST;
            setup_reg   <= SETUP_RST;
            avg_reg     <= AVG_RST;
            rst_reg     <= RSTR_RST;
            upair       <= UPAIR_RST;
            spair       <= SPAIR_RST;
            pend_pair   <= 1'b0;
            pend_signed <= 1'b0;
            conv_wr     <= 1'b0;
            fifo_clr    <= 1'b0;
        end else begin
            conv_wr  <= 1'b0;
            fifo_clr <= 1'b0;
            if (cs_rise) begin
                pend_pair <= 1'b0;
            end
            if (byte_stb) begin
                pend_pair <= 1'b0;
                if (pend_pair) begin
                    if (pend_signed) begin
                        spair <= byte_hold;
                    end else begin
                        upair <= byte_hold;
                    end
                end else if (byte_hold[CONV_SEL_BIT]) begin
                    conv_reg <= byte_hold;
                    conv_wr  <= 1'b1;
                end else if (byte_hold[SETUP_SEL_BIT]) begin
                    setup_reg   <= byte_hold;
                    pend_pair   <= byte_hold[PTR_HI];
                    pend_signed <= byte_hold[PTR_LO];
                end else if (byte_hold[AVG_SEL_BIT]) begin
                    avg_reg <= byte_hold;
                end else if (byte_hold[RST_SEL_BIT]) begin
                    rst_reg <= byte_hold;
                    if (byte_hold[RST_FIFO_BIT]) begin
                        fifo_clr <= 1'b1;
                    end else begin
                        conv_reg  <= CONV_RST;
                        setup_reg <= SETUP_RST;
                        avg_reg   <= AVG_RST;
                        upair     <= UPAIR_RST;
                        spair     <= SPAIR_RST;
                        rst_reg   <= RSTR_RST;
                    end
                end
                // upper nibble zero falls through untouched
            end
        end
    end

    logic [1:0] clk_mode, ref_mode;
    assign clk_mode   = setup_reg[CLK_HI:CLK_LO];
    assign ref_mode   = setup_reg[REF_HI:REF_LO];
    assign CLOCK_MODE = clk_mode;
    assign REF_MODE   = ref_mode;
    assign FIFO_CLEAR = fifo_clr;

    // per pair flags, pair 0/1 lives in bit 7; unsigned wins over signed
    logic [7:0] pair_diff, pair_sgn;
    for (genvar i = 0; i < 8; i++) begin : g_pair
        assign pair_diff[i] = upair[7-i] | spair[7-i];
        assign pair_sgn[i]  = spair[7-i] & ~upair[7-i];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // scan sequencer
    scan_state_t   state;
    scan_pattern_t pat;
    logic [1:0]    smode;
    logic [4:0]    sch, slast;
    logic [3:0]    sel_n;
    logic [15:0]   tim;
    logic [4:0]    rep_left;
    logic [5:0]    navg;
    logic [5:0]    res_cnt;
    logic          temp_req, wake_req;

    // triggered modes lend the top channel to the trigger pin
    logic trig_used, ref_used;
    assign trig_used = ~clk_mode[1];
    assign ref_used  = ref_mode != REF_EXT_DIFF;

    function automatic logic lent(input logic [4:0] c, input logic tu, input logic ru);
        lent = (tu && c == TOP_CH) || (ru && c == REF_CH);
    endfunction

    logic       cur_diff, skip, start;
    logic [4:0] partner, step;
    logic [15:0] slot;
    assign cur_diff = pair_diff[sch[3:1]];
    assign partner  = {sch[4:1], ~sch[0]};
    assign skip     = lent(sch, trig_used, ref_used)
                    | (cur_diff & (sch[0] | lent(partner, trig_used, ref_used)));
    assign step     = (cur_diff & ~sch[0]) ? 5'h2 : 5'h1;
    assign slot     = 16'(TCNV_CYC * navg);
    assign start    = (state == S_IDLE)
                    & ((conv_wr & clk_mode[1]) | (trig_fall & ~clk_mode[1]));

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            state    <= S_IDLE;
            pat      <= SCAN_ONCE;
            smode    <= 2'h0;
            sch      <= 5'h0;
            slast    <= 5'h0;
            sel_n    <= 4'h0;
            tim      <= 16'h0;
            rep_left <= 5'h0;
            navg     <= 6'h1;
            temp_req <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (start) begin
                        sel_n    <= conv_reg[CH_HI:CH_LO];
                        smode    <= clk_mode;
                        temp_req <= conv_reg[TEMP_BIT];
                        wake_req <= ref_mode == REF_INT_AUTO;
                        rep_left <= {avg_reg[REP_HI:REP_LO], 2'h0} + 5'h4;
                        if (clk_mode == CLK_SERIAL) begin
                            pat  <= SCAN_ONCE;
                            navg <= 6'h1;
                        end else begin
                            pat  <= scan_pattern_t'(conv_reg[SCAN_HI:SCAN_LO]);
                            navg <= avg_reg[MEAN_EN_BIT]
                                  ? 6'h4 << avg_reg[MEAN_HI:MEAN_LO] : 6'h1;
                        end
                        case (conv_reg[SCAN_HI:SCAN_LO])
                            SCAN_LOW_UP: begin
                                sch   <= 5'h0;
                                slast <= {1'b0, conv_reg[CH_HI:CH_LO]};
                            end
                            SCAN_UP_TOP: begin
                                sch   <= {1'b0, conv_reg[CH_HI:CH_LO]};
                                slast <= TOP_CH;
                            end
                            default: begin
                                sch   <= {1'b0, conv_reg[CH_HI:CH_LO]};
                                slast <= {1'b0, conv_reg[CH_HI:CH_LO]};
                            end
                        endcase
                        if (clk_mode == CLK_SERIAL) begin
                            sch   <= {1'b0, conv_reg[CH_HI:CH_LO]};
                            slast <= {1'b0, conv_reg[CH_HI:CH_LO]};
                        end
                        tim   <= 16'(TRP_CYC - 1);
                        state <= S_WAKE;
                    end
                end
                S_WAKE: begin
                    if (!wake_req || tim == 16'h0) begin
                        tim   <= 16'(TTS_CYC - 1);
                        state <= temp_req ? S_TEMP : S_SEEK;
                    end else begin
                        tim <= tim - 16'h1;
                    end
                end
                S_TEMP: begin
                    if (tim == 16'h0) begin
                        state <= S_SEEK;
                    end else begin
                        tim <= tim - 16'h1;
                    end
                end
                S_SEEK: begin
                    if (sch > slast) begin
                        state <= S_DONE;
                    end else if (skip) begin
                        sch   <= sch + step;
                        state <= (pat[1] || sch >= slast) ? S_DONE : S_SEEK;
                    end else begin
                        tim   <= slot - 16'h1;
                        state <= S_SAMPLE;
                    end
                end
                S_SAMPLE: begin
                    // slot ends by timer, by trigger release, or at once
                    if ((smode == CLK_SERIAL)
                        || (smode == CLK_TRIG_HLD && tr_s2)
                        || (!smode[0] && tim == 16'h0)) begin
                        if (pat == SCAN_REPEAT && rep_left > 5'h1) begin
                            rep_left <= rep_left - 5'h1;
                            state    <= (smode == CLK_TRIG_HLD) ? S_WAIT : S_SEEK;
                        end else if (pat[1]) begin
                            state <= S_DONE;
                        end else begin
                            sch   <= sch + step;
                            state <= (smode == CLK_TRIG_HLD) ? S_WAIT : S_SEEK;
                        end
                    end else if (tim != 16'h0) begin
                        tim <= tim - 16'h1;
                    end
                end
                S_WAIT: begin
                    if (sch > slast) begin
                        state <= S_DONE;
                    end else if (trig_fall) begin
                        state <= S_SEEK;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // request outputs
    logic emit_conv, emit_temp;
    assign emit_conv = (state == S_SEEK) && (sch <= slast) && !skip;
    assign emit_temp = (state == S_WAKE) && (!wake_req || tim == 16'h0) && temp_req;

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            REQ_VALID      <= 1'b0;
            REQ_CHANNEL    <= 4'h0;
            REQ_TEMP       <= 1'b0;
            REQ_DIFF       <= 1'b0;
            REQ_SIGNED     <= 1'b0;
            REQ_MEAN_COUNT <= 6'h1;
            SCAN_DONE      <= 1'b0;
            res_cnt        <= 6'h0;
        end else begin
            REQ_VALID <= emit_conv | emit_temp;
            SCAN_DONE <= state == S_DONE;
            if (start) begin
                res_cnt <= 6'h0;
            end else if (REQ_VALID) begin
                res_cnt <= res_cnt + 6'h1;
            end
            if (emit_temp) begin
                REQ_CHANNEL <= 4'h0;
                REQ_TEMP    <= 1'b1;
                REQ_DIFF    <= 1'b0;
                REQ_SIGNED  <= 1'b0;
            end else if (emit_conv) begin
                REQ_CHANNEL    <= sch[3:0];
                REQ_TEMP       <= 1'b0;
                REQ_DIFF       <= cur_diff;
                REQ_SIGNED     <= pair_sgn[sch[3:1]];
                REQ_MEAN_COUNT <= navg;
            end
        end
    end

    assign SCAN_BUSY = state != S_IDLE;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_conv_route;
        @(posedge REF_CLK) disable iff (!RESETN)
        byte_stb && !pend_pair && byte_hold[7] |=> conv_reg == $past(byte_hold) && conv_wr;
    endproperty
    a_conv_route: assert property (p_conv_route) else $error("conversion byte misrouted");

    property p_pair_write;
        @(posedge REF_CLK) disable iff (!RESETN)
        byte_stb && pend_pair && pend_signed && !cs_rise |=> spair == $past(byte_hold) && !pend_pair;
    endproperty
    a_pair_write: assert property (p_pair_write) else $error("signed pair byte lost");

    property p_ignore_zero;
        @(posedge REF_CLK) disable iff (!RESETN)
        byte_stb && !pend_pair && byte_hold[7:4] == 4'h0
            |=> $stable(conv_reg) && $stable(setup_reg) && $stable(avg_reg) && $stable(upair);
    endproperty
    a_ignore_zero: assert property (p_ignore_zero) else $error("null byte changed state");

    property p_write_start;
        @(posedge REF_CLK) disable iff (!RESETN)
        state == S_IDLE && conv_wr && setup_reg[CLK_HI] |=> state == S_WAKE ##1 state != S_IDLE;
    endproperty
    a_write_start: assert property (p_write_start) else $error("scan did not start");

    property p_no_lent;
        @(posedge REF_CLK) disable iff (!RESETN)
        REQ_VALID && !REQ_TEMP |-> !lent({1'b0, REQ_CHANNEL}, trig_used, ref_used);
    endproperty
    a_no_lent: assert property (p_no_lent) else $error("lent channel converted");

    property p_temp_first;
        @(posedge REF_CLK) disable iff (!RESETN)
        REQ_VALID && REQ_TEMP |-> res_cnt == 6'h0;
    endproperty
    a_temp_first: assert property (p_temp_first) else $error("temperature not first");

    property p_low_up;
        @(posedge REF_CLK) disable iff (!RESETN)
        REQ_VALID && !REQ_TEMP && pat == SCAN_LOW_UP |-> REQ_CHANNEL <= sel_n;
    endproperty
    a_low_up: assert property (p_low_up) else $error("channel above N in pattern 00");

    property p_up_top;
        @(posedge REF_CLK) disable iff (!RESETN)
        REQ_VALID && !REQ_TEMP && pat == SCAN_UP_TOP |-> REQ_CHANNEL >= sel_n;
    endproperty
    a_up_top: assert property (p_up_top) else $error("channel below N in pattern 01");

    property p_serial_once;
        @(posedge REF_CLK) disable iff (!RESETN)
        REQ_VALID && smode == CLK_SERIAL |-> res_cnt == 6'(temp_req) && REQ_MEAN_COUNT == 6'h1;
    endproperty
    a_serial_once: assert property (p_serial_once) else $error("mode 11 scanned");

    property p_slot_len;
        @(posedge REF_CLK) disable iff (!RESETN)
        $rose(state == S_SAMPLE) && !smode[0] |-> (state == S_SAMPLE)[*8];
    endproperty
    a_slot_len: assert property (p_slot_len) else $error("timed slot too short");

    property p_no_mean;
        @(posedge REF_CLK) disable iff (!RESETN)
        emit_conv && !avg_reg[MEAN_EN_BIT] |=> REQ_MEAN_COUNT == 6'h1;
    endproperty
    a_no_mean: assert property (p_no_mean) else $error("mean without enable");

    property p_cov_temp;
        @(posedge REF_CLK) disable iff (!RESETN)
        REQ_VALID && REQ_TEMP ##[1:1000] REQ_VALID && !REQ_TEMP;
    endproperty
    c_cov_temp: cover property (p_cov_temp);

    property p_cov_pair;
        @(posedge REF_CLK) disable iff (!RESETN)
        byte_stb && pend_pair;
    endproperty
    c_cov_pair: cover property (p_cov_pair);

    property p_cov_done;
        @(posedge REF_CLK) disable iff (!RESETN)
        SCAN_DONE && pat == SCAN_REPEAT;
    endproperty
    c_cov_done: cover property (p_cov_done);

endmodule

//--- verif/spi_host_model.sv
// host side serial master that writes command bytes into the decoder
`timescale 1ns/100ps
module spi_host_model (
    output logic SCLK,
    output logic CS_N,
    output logic DIN
);
    initial begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        DIN  = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one framed byte, msb first, 80 ns serial clock only inside the frame
    task automatic send(input logic [7:0] b);
        #7;
        CS_N = 1'b0;
        #40;
        for (int i = 7; i >= 0; i--) begin
            DIN = b[i];
            #40 SCLK = 1'b1;
            #40 SCLK = 1'b0;
        end
        #40 CS_N = 1'b1;
        // released line shows the inverse so a stale bit never looks valid
        DIN = ~DIN;
        #200;
    endtask
    // setup byte plus its pair byte inside one frame, 16 serial clocks
    task automatic send2(input logic [15:0] w);
        #7;
        CS_N = 1'b0;
        #40;
        for (int i = 15; i >= 0; i--) begin
            DIN = w[i];
            #40 SCLK = 1'b1;
            #40 SCLK = 1'b0;
        end
        #40 CS_N = 1'b1;
        DIN = ~DIN;
        #200;
    endtask
endmodule

//--- verif/tb_top.sv
// self-checking bench for the command byte decoder
`timescale 1ns/100ps
module tb_top;
    logic       REF_CLK, RESETN, SAMPLE_TRIG_N, SCLK, CS_N, DIN;
    logic       REQ_VALID, REQ_TEMP, REQ_DIFF, REQ_SIGNED, SCAN_BUSY, SCAN_DONE, FIFO_CLEAR;
    logic [3:0] REQ_CHANNEL, first_ch, last_ch;
    logic [5:0] REQ_MEAN_COUNT;
    logic [1:0] CLOCK_MODE, REF_MODE;
    logic       first_temp, done_seen, clr_seen;
    int         num_errors, compares, nreq;
    adc_command_byte_decoder u_dut (.REF_CLK(REF_CLK), .RESETN(RESETN), .SCLK(SCLK),
        .CS_N(CS_N), .DIN(DIN), .SAMPLE_TRIG_N(SAMPLE_TRIG_N), .REQ_VALID(REQ_VALID),
        .REQ_CHANNEL(REQ_CHANNEL), .REQ_TEMP(REQ_TEMP), .REQ_DIFF(REQ_DIFF),
        .REQ_SIGNED(REQ_SIGNED), .REQ_MEAN_COUNT(REQ_MEAN_COUNT), .SCAN_BUSY(SCAN_BUSY),
        .SCAN_DONE(SCAN_DONE), .FIFO_CLEAR(FIFO_CLEAR), .CLOCK_MODE(CLOCK_MODE),
        .REF_MODE(REF_MODE));
    spi_host_model u_host (.SCLK(SCLK), .CS_N(CS_N), .DIN(DIN));
    initial begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end
    ////////////////////////////////////////////////////////////////////////
    // request monitor: one-cycle pulses are sampled in their own cycle
    always @(posedge REF_CLK) begin
        if (REQ_VALID === 1'b1) begin
            if (nreq == 0) first_temp = REQ_TEMP;
            if (nreq == 0) first_ch = REQ_CHANNEL;
            last_ch = REQ_CHANNEL;
            nreq++;
        end
        if (SCAN_DONE === 1'b1) done_seen = 1'b1;
        if (FIFO_CLEAR === 1'b1) clr_seen = 1'b1;
    end
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] b);
        @(posedge REF_CLK);
        #1 clr_seen = 1'b0;
        u_host.send(b);
        // sync plus write takes at most four edges
        repeat (6) @(posedge REF_CLK);
    endtask
    task automatic wr2(input logic [15:0] w);
        @(posedge REF_CLK);
        u_host.send2(w);
        repeat (6) @(posedge REF_CLK);
    endtask
    task automatic modes(input logic [1:0] ck, input logic [1:0] rf);
        check("clock_mode", {6'h00, ck}, {6'h00, CLOCK_MODE});
        check("ref_mode", {6'h00, rf}, {6'h00, REF_MODE});
    endtask
    task automatic scan(input logic [7:0] b, input int n, input logic [3:0] f,
                        input logic [3:0] l, input logic t, input string name);
        @(posedge REF_CLK);
        #1 nreq = 0;
        done_seen = 1'b0;
        if (b == 8'h00) begin
            SAMPLE_TRIG_N = 1'b0;
            repeat (4) @(posedge REF_CLK);
            #1 SAMPLE_TRIG_N = 1'b1;
        end else u_host.send(b);
        for (int i = 0; i < 20000 && !done_seen; i++) @(posedge REF_CLK);
        check("requests", 8'(n), 8'(nreq));
        check("first_channel", {4'h0, f}, {4'h0, first_ch});
        check("last_channel", {4'h0, l}, {4'h0, last_ch});
        check("first_is_temp", {7'h00, t}, {7'h00, first_temp});
        check("scan_busy", 8'h00, {7'h00, SCAN_BUSY});
        $display("test %s done", name);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // host never asks for channels the part lacks (default 16 channels)
    initial begin
        RESETN = 1'b0;
        SAMPLE_TRIG_N = 1'b1;
        num_errors = 0;
        compares = 0;
        nreq = 0;
        clr_seen = 1'b0;
        repeat (4) @(posedge REF_CLK);
        #1 RESETN = 1'b1;
        modes(2'h2, 2'h0);
        wr(8'h68);
        modes(2'h2, 2'h2);
        wr(8'h0f);
        modes(2'h2, 2'h2);
        scan(8'h9e, 1, 4'h3, 4'h3, 1'b0, "single");
        scan(8'h91, 4, 4'h0, 4'h2, 1'b1, "low_up");
        scan(8'he2, 3, 4'hc, 4'hf, 1'b0, "up_top");
        scan(8'hac, 4, 4'h5, 4'h5, 1'b0, "repeat");
        check("mean_count_off", 8'h01, {2'h0, REQ_MEAN_COUNT});
        wr(8'h30);
        wr2(16'h6a80);
        scan(8'h86, 1, 4'h0, 4'h0, 1'b0, "pair");
        check("pair_diff", 8'h01, {7'h00, REQ_DIFF});
        check("pair_signed", 8'h00, {7'h00, REQ_SIGNED});
        check("mean_count", 8'h04, {2'h0, REQ_MEAN_COUNT});
        wr(8'h48);
        wr(8'h9e);
        scan(8'h00, 1, 4'h3, 4'h3, 1'b0, "trigger");
        wr(8'h18);
        check("fifo_clear", 8'h01, {7'h00, clr_seen});
        wr(8'h10);
        modes(2'h2, 2'h0);
        test_done;
    end
    initial begin
        #600000;
        num_errors++;
        test_done;
    end
endmodule
